// *** core/fbs_mode_cfg.sv ***
// fieldbus slave mode configuration bits behind an apb slave
`timescale 1ns/1ps
`include "fbs_cfg.svh"

// Behaviour
// RULE1: with slave protocol enabled and online, every service access point is set up.
// RULE2: with the inactive timebase at 0, interrupt stays low at least 1 us after end of interrupt.
// RULE3: with the inactive timebase at 1, that low time stretches to at least 1 ms.
// RULE4: with the tick timebase at 0, the user tick event fires once every 1 ms.
// RULE5: with the tick timebase at 1, the user tick event fires once every 10 ms.
// RULE6: watchdog test select at 0 runs the watchdog normally; software must never write 1.
// RULE7: with the special buffer bit at 0, parameter bytes go out on the normal path.
// RULE8: software changes the mode bits only while offline, never during bus operation.
// RULE9: an end of interrupt command drives the interrupt low and its bit clears itself.
// RULE10: with the special buffer bit at 1, parameter bytes are stored in the special buffer.
module fbs_mode_cfg #(
	parameter int NUM_SAPS       = 8,
	parameter int PRM_DEPTH      = 32,
	parameter int EOI_LONG_CYC   = `FBS_EOI_LONG_CYC,
	parameter int TICK_SHORT_CYC = `FBS_TICK_SHORT_CYC,
	parameter int TICK_LONG_CYC  = `FBS_TICK_LONG_CYC
) (
	input  wire logic              clock,
	input  wire logic              rstn,
	input  wire logic              psel,
	input  wire logic              penable,
	input  wire logic              pwrite,
	input  wire logic [7:0]        paddr,
	input  wire logic [31:0]       pwdata,
	input  wire logic [3:0]        pstrb,
	output logic      [31:0]       prdata,
	output logic                   pready,
	output logic                   pslverr,
	output logic                   irq,
	output logic                   online,
	output logic      [NUM_SAPS-1:0] slave_service_points,
	output logic                   watchdog_normal,
	input  wire fbs_pkg::fbs_prm_t prm_in,
	output fbs_pkg::fbs_prm_t      prm_fwd
);

	localparam int CNT_W = 20;
	localparam int PAW   = $clog2(PRM_DEPTH);
	localparam int NEV   = `FBS_NUM_EVENTS;
	localparam logic [CNT_W-1:0] EOI_SHORT = CNT_W'(`FBS_EOI_SHORT_CYC);
	localparam logic [CNT_W-1:0] EOI_LONG  = CNT_W'(EOI_LONG_CYC);
	localparam logic [CNT_W-1:0] TICK_SHRT = CNT_W'(TICK_SHORT_CYC - 1);
	localparam logic [CNT_W-1:0] TICK_LNG  = CNT_W'(TICK_LONG_CYC - 1);

	fbs_pkg::fbs_state_t state;
	fbs_pkg::fbs_mode_t  mode;
	logic [NEV-1:0]      irq_stat;
	logic [NEV-1:0]      irq_mask;
	logic [NEV-1:0]      events;
	logic                eoi_cmd;
	logic [CNT_W-1:0]    holdoff_cnt;
	logic [CNT_W-1:0]    tick_cnt;
	logic                tick_pulse;
	logic                tick_wrap;
	logic                prm_rd_setup;
	logic [PAW:0]        prm_count;
	logic [PAW-1:0]      prm_rd_addr;
	logic [7:0]          prm_rd_data;
	logic                prm_read_wait;
	logic                prm_store;
	logic                prm_overflow;
	logic                setup;
	logic                ack;
	logic                wr;
	logic [31:0]         wmask;
	logic [31:0]         rd_value;
	logic                rd_error;
	logic                next_irq;

	// byte offset match on word aligned registers
	function automatic logic fbs_hit(input logic [7:0] addr, input logic [7:0] off);
		return addr[7:2] == off[7:2];
	endfunction

	// expand byte strobes into a bit mask
	function automatic logic [31:0] fbs_lanes(input logic [3:0] strb);
		return {{8{strb[3]}}, {8{strb[2]}}, {8{strb[1]}}, {8{strb[0]}}};
	endfunction

	// apb phase decode
	assign setup = psel && !penable;
	assign ack   = psel && penable && pready;
	assign wr    = ack && pwrite;
	assign wmask = pwdata & fbs_lanes(pstrb);
	assign prm_rd_setup = setup && !pwrite && fbs_hit(paddr, `FBS_OFF_PRM_DATA);

	// offline and online, entered through the control register
	always_ff @(posedge clock) begin
		if (!rstn) begin
			state <= fbs_pkg::FBS_OFFLINE;
		end else begin
			unique case (state)
				fbs_pkg::FBS_OFFLINE: begin
					if (wr && fbs_hit(paddr, `FBS_OFF_CTRL) && wmask[`FBS_BIT_START]) begin
						state <= fbs_pkg::FBS_ONLINE;
					end
				end
				fbs_pkg::FBS_ONLINE: begin
					if (wr && fbs_hit(paddr, `FBS_OFF_CTRL) && wmask[`FBS_BIT_GO_OFFLINE]) begin
						state <= fbs_pkg::FBS_OFFLINE;
					end
				end
			endcase
		end
	end

	// mode bits; writes while online are dropped so a stray write cannot disturb bus operation
	always_ff @(posedge clock) begin
		if (!rstn) begin
			mode <= `FBS_RST_MODE;
		end else if (wr && fbs_hit(paddr, `FBS_OFF_MODE) && pstrb[1]) begin
			if (state == fbs_pkg::FBS_OFFLINE) begin // RULE8
				mode.slave_protocol_enable <= pwdata[`FBS_BIT_SLAVE_PROTOCOL];
				mode.irq_inactive_timebase <= pwdata[`FBS_BIT_IRQ_TIMEBASE];
				mode.tick_timebase         <= pwdata[`FBS_BIT_TICK_TIMEBASE];
				mode.watchdog_test_select  <= pwdata[`FBS_BIT_WATCHDOG_TEST_SELECT];
				mode.special_prm_buffer    <= pwdata[`FBS_BIT_SPECIAL_PRM];
			end
		end
	end

	// end of interrupt command lives for one cycle, then reads back as zero
	always_ff @(posedge clock) begin
		if (!rstn) begin
			eoi_cmd <= 1'b0;
		end else begin
			eoi_cmd <= wr && fbs_hit(paddr, `FBS_OFF_CTRL) && wmask[`FBS_BIT_EOI]; // RULE9
		end
	end

	// inactive time after end of interrupt, loaded from the selected timebase
	always_ff @(posedge clock) begin
		if (!rstn) begin
			holdoff_cnt <= '0;
		end else if (eoi_cmd) begin
			holdoff_cnt <= mode.irq_inactive_timebase ? EOI_LONG : EOI_SHORT; // RULE2 RULE3
		end else if (holdoff_cnt != '0) begin
			holdoff_cnt <= holdoff_cnt - CNT_W'(1);
		end
	end

	// user tick wrap point; >= keeps a shortened period safe after a timebase change
	assign tick_wrap = tick_cnt >= (mode.tick_timebase ? TICK_LNG : TICK_SHRT); // RULE4 RULE5

	// user tick divider
	always_ff @(posedge clock) begin
		if (!rstn) begin
			tick_cnt <= '0;
		end else if (tick_wrap) begin
			tick_cnt <= '0;
		end else begin
			tick_cnt <= tick_cnt + CNT_W'(1);
		end
	end

	// one cycle tick event at each wrap
	always_ff @(posedge clock) begin
		if (!rstn) begin
			tick_pulse <= 1'b0;
		end else begin
			tick_pulse <= tick_wrap;
		end
	end

	// parameter byte steering between special buffer and normal path
	assign prm_store    = prm_in.valid && online && mode.special_prm_buffer
		&& (prm_count != (PAW+1)'(PRM_DEPTH));
	assign prm_overflow = prm_in.valid && online && mode.special_prm_buffer
		&& (prm_count == (PAW+1)'(PRM_DEPTH));

	// fill level restarts with every start so a new parameter set begins at word 0
	always_ff @(posedge clock) begin
		if (!rstn) begin
			prm_count <= '0;
		end else if (wr && fbs_hit(paddr, `FBS_OFF_CTRL) && wmask[`FBS_BIT_START]
				&& state == fbs_pkg::FBS_OFFLINE) begin
			prm_count <= '0;
		end else if (prm_store) begin // RULE10
			prm_count <= prm_count + (PAW+1)'(1);
		end
	end

	// normal path output, only when the special buffer is off
	always_ff @(posedge clock) begin
		if (!rstn) begin
			prm_fwd <= '0;
		end else begin
			prm_fwd.valid <= prm_in.valid && online && !mode.special_prm_buffer; // RULE7
			prm_fwd.data  <= prm_in.data;
		end
	end

	fbs_prm_mem #(
		.WIDTH (8),
		.DEPTH (PRM_DEPTH),
		.AW    (PAW)
	) i_fbs_prm_mem (
		.clock   (clock),
		.rstn    (rstn),
		.wr_en   (prm_store), // RULE10
		.wr_addr (prm_count[PAW-1:0]),
		.wr_data (prm_in.data),
		.rd_en   (prm_rd_setup),
		.rd_addr (prm_rd_addr),
		.rd_data (prm_rd_data)
	);

	// readback address into the special buffer
	always_ff @(posedge clock) begin
		if (!rstn) begin
			prm_rd_addr <= '0;
		end else if (wr && fbs_hit(paddr, `FBS_OFF_PRM_ADDR) && pstrb[0]) begin
			prm_rd_addr <= pwdata[PAW-1:0];
		end
	end

	// event sources of the sticky status bits
	always_comb begin
		events                        = '0;
		events[`FBS_EV_TICK]          = tick_pulse;
		events[`FBS_EV_PRM_STORED]    = prm_store;
		events[`FBS_EV_PRM_FORWARDED] = prm_in.valid && online && !mode.special_prm_buffer;
		events[`FBS_EV_PRM_OVERFLOW]  = prm_overflow;
	end

	// sticky status, write one to clear; a new event beats a clear in the same cycle
	for (genvar i = 0; i < NEV; i++) begin : g_stat
		always_ff @(posedge clock) begin
			if (!rstn) begin
				irq_stat[i] <= 1'b0;
			end else if (events[i]) begin
				irq_stat[i] <= 1'b1;
			end else if (wr && fbs_hit(paddr, `FBS_OFF_IRQ_STAT) && wmask[i]) begin
				irq_stat[i] <= 1'b0;
			end
		end
	end

	// interrupt mask, one bit per event
	always_ff @(posedge clock) begin
		if (!rstn) begin
			irq_mask <= `FBS_RST_IRQ_MASK;
		end else if (wr && fbs_hit(paddr, `FBS_OFF_IRQ_MASK) && pstrb[0]) begin
			irq_mask <= pwdata[NEV-1:0];
		end
	end

	// interrupt level, forced low by the command and through the whole inactive time
	assign next_irq = |(irq_stat & irq_mask) && !eoi_cmd && (holdoff_cnt == '0); // RULE9 RULE2 RULE3

	always_ff @(posedge clock) begin
		if (!rstn) begin
			irq <= 1'b0;
		end else begin
			irq <= next_irq;
		end
	end

	// online flag toward the protocol machine
	always_ff @(posedge clock) begin
		if (!rstn) begin
			online <= 1'b0;
		end else begin
			online <= (state == fbs_pkg::FBS_ONLINE);
		end
	end

	// service access points follow the protocol enable, only while online
	always_ff @(posedge clock) begin
		if (!rstn) begin
			slave_service_points <= '0;
		end else begin
			slave_service_points <= {NUM_SAPS{mode.slave_protocol_enable
				&& state == fbs_pkg::FBS_ONLINE}}; // RULE1
		end
	end

	// watchdog mode; the forbidden test setting is stored, not blocked
	always_ff @(posedge clock) begin
		if (!rstn) begin
			watchdog_normal <= 1'b1;
		end else begin
			watchdog_normal <= !mode.watchdog_test_select; // RULE6
		end
	end

	// read value and unmapped check, evaluated in the setup cycle
	always_comb begin
		rd_value = '0;
		rd_error = 1'b0;
		if (fbs_hit(paddr, `FBS_OFF_MODE)) begin
			rd_value[`FBS_BIT_SLAVE_PROTOCOL] = mode.slave_protocol_enable;
			rd_value[`FBS_BIT_IRQ_TIMEBASE]   = mode.irq_inactive_timebase;
			rd_value[`FBS_BIT_TICK_TIMEBASE]  = mode.tick_timebase;
			rd_value[`FBS_BIT_WATCHDOG_TEST_SELECT]        = mode.watchdog_test_select;
			rd_value[`FBS_BIT_SPECIAL_PRM]    = mode.special_prm_buffer;
		end else if (fbs_hit(paddr, `FBS_OFF_CTRL)) begin
			rd_value[`FBS_BIT_EOI] = eoi_cmd;
		end else if (fbs_hit(paddr, `FBS_OFF_IRQ_STAT)) begin
			rd_value[NEV-1:0] = irq_stat;
		end else if (fbs_hit(paddr, `FBS_OFF_IRQ_MASK)) begin
			rd_value[NEV-1:0] = irq_mask;
		end else if (fbs_hit(paddr, `FBS_OFF_STATUS)) begin
			rd_value[`FBS_BIT_STAT_ONLINE]      = (state == fbs_pkg::FBS_ONLINE);
			rd_value[`FBS_BIT_STAT_HOLDOFF]     = (holdoff_cnt != '0);
			rd_value[`FBS_BIT_STAT_FULL]        = (prm_count == (PAW+1)'(PRM_DEPTH));
			rd_value[`FBS_BIT_STAT_FILL+:PAW+1] = prm_count;
		end else if (fbs_hit(paddr, `FBS_OFF_PRM_ADDR)) begin
			rd_value[PAW-1:0] = prm_rd_addr;
		end else if (!fbs_hit(paddr, `FBS_OFF_PRM_DATA)) begin
			rd_error = 1'b1;
		end
	end

	// buffer reads cost one extra wait state because the ram output is registered
	always_ff @(posedge clock) begin
		if (!rstn) begin
			prm_read_wait <= 1'b0;
		end else begin
			prm_read_wait <= prm_rd_setup;
		end
	end

	// apb answer registers: no wait state, one for buffer reads
	always_ff @(posedge clock) begin
		if (!rstn) begin
			pready  <= 1'b0;
			pslverr <= 1'b0;
			prdata  <= '0;
		end else if (ack) begin
			pready  <= 1'b0;
			pslverr <= 1'b0;
			prdata  <= '0;
		end else if (prm_read_wait) begin
			pready  <= 1'b1;
			prdata  <= {24'h000000, prm_rd_data};
		end else if (setup && !prm_rd_setup) begin
			pready  <= 1'b1;
			pslverr <= rd_error;
			prdata  <= pwrite ? 32'h00000000 : rd_value;
		end
	end

endmodule

// *** include/fbs_cfg.svh ***
// offsets, field positions, reset values and timing counts of the mode configuration block
`ifndef FBS_CFG_SVH
`define FBS_CFG_SVH

// register byte offsets on the apb bus
`define FBS_OFF_MODE      8'h00
`define FBS_OFF_CTRL      8'h04
`define FBS_OFF_IRQ_STAT  8'h08
`define FBS_OFF_IRQ_MASK  8'h0c
`define FBS_OFF_STATUS    8'h10
`define FBS_OFF_PRM_ADDR  8'h14
`define FBS_OFF_PRM_DATA  8'h18

// mode register field positions
`define FBS_BIT_SLAVE_PROTOCOL   8
`define FBS_BIT_IRQ_TIMEBASE     9
`define FBS_BIT_TICK_TIMEBASE    10
`define FBS_BIT_WATCHDOG_TEST_SELECT          11
`define FBS_BIT_SPECIAL_PRM      12

// control register field positions
`define FBS_BIT_START            0
`define FBS_BIT_EOI              1
`define FBS_BIT_GO_OFFLINE       2

// status register field positions
`define FBS_BIT_STAT_ONLINE      0
`define FBS_BIT_STAT_HOLDOFF     1
`define FBS_BIT_STAT_FULL        2
`define FBS_BIT_STAT_FILL        8

// interrupt event positions
`define FBS_EV_TICK              0
`define FBS_EV_PRM_STORED        1
`define FBS_EV_PRM_FORWARDED     2
`define FBS_EV_PRM_OVERFLOW      3
`define FBS_NUM_EVENTS           4

// reset values
`define FBS_RST_MODE             5'h00
`define FBS_RST_IRQ_MASK         4'h0

// timing, each figure in its own unit, then cycles at the clock rate
`define FBS_CLK_MHZ              100
`define FBS_EOI_SHORT_US         1
`define FBS_EOI_LONG_MS          1
`define FBS_TICK_SHORT_MS        1
`define FBS_TICK_LONG_MS         10
`define FBS_EOI_SHORT_CYC        (`FBS_EOI_SHORT_US * `FBS_CLK_MHZ)
`define FBS_EOI_LONG_CYC         (`FBS_EOI_LONG_MS * 1000 * `FBS_CLK_MHZ)
`define FBS_TICK_SHORT_CYC       (`FBS_TICK_SHORT_MS * 1000 * `FBS_CLK_MHZ)
`define FBS_TICK_LONG_CYC        (`FBS_TICK_LONG_MS * 1000 * `FBS_CLK_MHZ)

`endif

// *** include/fbs_pkg.sv ***
// types shared by the mode configuration block
package fbs_pkg;

	// operating state of the slave, one-hot
	typedef enum logic [1:0] {
		FBS_OFFLINE = 2'b01,
		FBS_ONLINE  = 2'b10
	} fbs_state_t;

	// configuration bits of the mode register
	typedef struct packed {
		logic special_prm_buffer;
		logic watchdog_test_select;
		logic tick_timebase;
		logic irq_inactive_timebase;
		logic slave_protocol_enable;
	} fbs_mode_t;

	// one parameterization byte with its strobe
	typedef struct packed {
		logic       valid;
		logic [7:0] data;
	} fbs_prm_t;

endpackage

// *** core/fbs_prm_mem.sv ***
// special parameter buffer storage with registered read data
`timescale 1ns/1ps

module fbs_prm_mem #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 32,
	parameter int AW    = $clog2(DEPTH)
) (
	input  wire logic             clock,
	input  wire logic             rstn,
	input  wire logic             wr_en,
	input  wire logic [AW-1:0]    wr_addr,
	input  wire logic [WIDTH-1:0] wr_data,
	input  wire logic             rd_en,
	input  wire logic [AW-1:0]    rd_addr,
	output logic      [WIDTH-1:0] rd_data
);

	logic [WIDTH-1:0] mem [DEPTH];

	// array carries no reset so it maps onto plain ram
	always_ff @(posedge clock) begin
		if (wr_en) begin
			mem[wr_addr] <= wr_data;
		end
	end

	// read data from a register, one cycle after rd_en
	always_ff @(posedge clock) begin
		if (!rstn) begin
			rd_data <= '0;
		end else if (rd_en) begin
			rd_data <= mem[rd_addr];
		end
	end

endmodule

// *** tb/fbs_mode_cfg_asserts.sv ***
// port-level assertions for the mode configuration block
`timescale 1ns/1ps

module fbs_mode_cfg_asserts #(
	parameter int NUM_SAPS     = 8,
	parameter int EOI_LONG_CYC = 300
) (
	input wire logic                clock,
	input wire logic                rstn,
	input wire logic                psel,
	input wire logic                penable,
	input wire logic                pwrite,
	input wire logic [7:0]          paddr,
	input wire logic [31:0]         pwdata,
	input wire logic [3:0]          pstrb,
	input wire logic                pready,
	input wire logic                pslverr,
	input wire logic                irq,
	input wire logic                online,
	input wire logic [NUM_SAPS-1:0] slave_service_points,
	input wire logic                watchdog_normal,
	input wire fbs_pkg::fbs_prm_t   prm_in,
	input wire fbs_pkg::fbs_prm_t   prm_fwd
);
	logic       ack;
	logic       eoi_ack;
	logic [4:0] m;
	int         cnt;
	int         lim;

	// accepted transfers and end of interrupt commands
	assign ack = psel & penable & pready;
	assign eoi_ack = ack & pwrite & (paddr[7:2] == 6'h01) & pwdata[1] & pstrb[0];

	// shadow of the mode bits; online writes are dropped by the block
	always_ff @(posedge clock) begin
		if (!rstn) m <= 5'h00;
		else if (ack && pwrite && paddr[7:2] == 6'h00 && pstrb[1] && !online) m <= pwdata[12:8];
	end

	// low span owed after each command, restarted by a repeat
	always_ff @(posedge clock) begin
		if (!rstn) cnt <= 0;
		else if (eoi_ack) cnt <= m[1] ? EOI_LONG_CYC + 1 : 101;
		else if (cnt != 0) cnt <= cnt - 1;
	end
	always_ff @(posedge clock) begin
		if (!rstn) lim <= 0;
		else if (eoi_ack) lim <= m[1] ? EOI_LONG_CYC : 100;
	end

	default clocking cb @(posedge clock);
	endclocking
	default disable iff (!rstn);

	property p_ready_next;
		psel && !penable && paddr[7:2] != 6'h06 |=> pready;
	endproperty
	a_ready_next: assert property (p_ready_next) else $error("no answer after setup");
	property p_ready_pulse;
		pready |=> !pready;
	endproperty
	a_ready_pulse: assert property (p_ready_pulse) else $error("ready held");
	property p_slverr;
		pready |-> pslverr == (paddr[7:2] > 6'h06);
	endproperty
	a_slverr: assert property (p_slverr) else $error("wrong error flag");
	property p_sap_on;
		online && $past(online, 2) |-> slave_service_points == {NUM_SAPS{m[0]}};
	endproperty
	a_sap_on: assert property (p_sap_on) else $error("service points wrong");
	property p_sap_off;
		!online && !$past(online) |-> slave_service_points == '0;
	endproperty
	a_sap_off: assert property (p_sap_off) else $error("service points offline");
	property p_holdoff;
		cnt != 0 && cnt < lim |-> !irq;
	endproperty
	a_holdoff: assert property (p_holdoff) else $error("irq back too soon");
	property p_eoi_drop;
		eoi_ack |=> ##[1:2] !irq;
	endproperty
	a_eoi_drop: assert property (p_eoi_drop) else $error("irq not dropped");
	property p_wd;
		$stable(m) |-> watchdog_normal == !m[3];
	endproperty
	a_wd: assert property (p_wd) else $error("watchdog mode wrong");
	property p_fwd;
		prm_in.valid && online && !m[4] |=> prm_fwd.valid && prm_fwd.data == $past(prm_in.data);
	endproperty
	a_fwd: assert property (p_fwd) else $error("byte not forwarded");
	property p_no_fwd;
		m[4] |=> !prm_fwd.valid;
	endproperty
	a_no_fwd: assert property (p_no_fwd) else $error("byte forwarded");

	c_eoi: cover property (eoi_ack);
	c_fwd: cover property (prm_fwd.valid);
	c_sap: cover property (online && &slave_service_points);
endmodule

// *** tb/fbs_mode_cfg_tb.sv ***
// self-checking bench for the mode configuration block
`timescale 1ns/1ps

module fbs_mode_cfg_tb;
	logic              clock = 1'b0;
	logic              rstn = 1'b0;
	logic              psel = 1'b0;
	logic              penable = 1'b0;
	logic              pwrite = 1'b0;
	logic [7:0]        paddr = 8'h00;
	logic [31:0]       pwdata = 32'h0;
	logic [3:0]        pstrb = 4'hf;
	logic [31:0]       prdata;
	logic              pready;
	logic              pslverr;
	logic              irq;
	logic              online;
	logic [7:0]        sap;
	logic              wdn;
	fbs_pkg::fbs_prm_t prm_in = '0;
	fbs_pkg::fbs_prm_t prm_fwd;
	logic [31:0]       q;
	logic              err;
	logic [7:0]        last_fwd = 8'h00;
	int                mismatches = 0;
	int                samples_checked = 0;

	always #5 clock = ~clock;

	fbs_mode_cfg #(.EOI_LONG_CYC(300), .TICK_SHORT_CYC(200), .TICK_LONG_CYC(500)) i_fbs_mode_cfg (
		.clock(clock), .rstn(rstn), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .irq(irq), .online(online), .slave_service_points(sap),
		.watchdog_normal(wdn), .prm_in(prm_in), .prm_fwd(prm_fwd));

	// last forwarded byte, kept for later comparison
	always @(posedge clock) begin
		if (prm_fwd.valid === 1'b1) last_fwd <= prm_fwd.data;
	end

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			mismatches++;
			$display("Error at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask

	// one apb transfer; idle cycle first so strobes never double up
	task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
		int k;
		k = 0;
		@(posedge clock);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clock);
		penable <= 1'b1;
		do begin
			@(posedge clock);
			k++;
		end while (pready !== 1'b1 && k < 50);
		q = prdata;
		err = pslverr;
		if (k == 50) chk(32'h1, 32'h0);
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic rdc(input logic [7:0] a, input logic [31:0] e, input logic [31:0] msk = '1);
		xfer(1'b0, a, 32'h0);
		chk(q & msk, e);
	endtask

	// bounded wait for an interrupt level
	task automatic wirq(input logic v, output int n);
		n = 0;
		while (irq !== v && n < 3000) begin
			@(posedge clock);
			n++;
		end
		if (n == 3000) chk(32'h1, 32'h0);
	endtask

	// rise to rise spacing of the tick interrupt
	task automatic tick_per(input int per);
		int  n;
		time t0;
		xfer(1'b1, 8'h08, 32'hf);
		// a tick landing on the clear wins, so clear once more
		repeat (3) @(posedge clock);
		if (irq === 1'b1) xfer(1'b1, 8'h08, 32'hf);
		wirq(1'b0, n);
		wirq(1'b1, n);
		t0 = $time;
		xfer(1'b1, 8'h08, 32'h1);
		wirq(1'b0, n);
		wirq(1'b1, n);
		chk(32'(($time - t0) / 10), 32'(per));
	endtask

	// low span of irq after an end of interrupt command
	task automatic eoi_low(input int lim);
		int n0;
		int n1;
		xfer(1'b1, 8'h04, 32'h2);
		wirq(1'b0, n0);
		wirq(1'b1, n1);
		chk(32'(n0 <= 3), 32'h1);
		chk(32'(n0 + n1 > lim && n0 + n1 < lim + 5), 32'h1);
	endtask

	task automatic byte_in(input logic [7:0] d);
		@(posedge clock);
		prm_in <= {1'b1, d};
		@(posedge clock);
		prm_in <= '0;
	endtask

	task automatic end_of_test();
		$display("checks %0d mismatches %0d", samples_checked, mismatches);
		if (mismatches == 0 && samples_checked > 0) $display("Regression OK");
		else $display("Regression broken");
		$finish;
	endtask

	// hang guard, about sixteen times the expected run
	initial begin
		#300000;
		mismatches++;
		end_of_test();
	end

	initial begin
		repeat (20) @(posedge clock);
		rstn <= 1'b1;
		rdc(8'h00, 32'h0);
		rdc(8'h0c, 32'h0);
		xfer(1'b0, 8'h1c, 32'h0);
		chk(32'(err), 32'h1);
		chk(32'(wdn), 32'h1);
		chk(32'(sap), 32'h0);
		chk(32'(online), 32'h0);
		$display("reset test done");
		xfer(1'b1, 8'h00, 32'h100);
		xfer(1'b1, 8'h04, 32'h1);
		xfer(1'b1, 8'h00, 32'h1600);
		rdc(8'h00, 32'h100);
		chk(32'(online), 32'h1);
		chk(32'(sap), 32'hff);
		byte_in(8'ha5);
		rdc(8'h08, 32'h4, 32'h4);
		chk(32'(last_fwd), 32'ha5);
		$display("online test done");
		xfer(1'b1, 8'h0c, 32'h1);
		tick_per(200);
		eoi_low(100);
		rdc(8'h04, 32'h0);
		$display("short timing test done");
		xfer(1'b1, 8'h04, 32'h4);
		xfer(1'b1, 8'h00, 32'h1600);
		rdc(8'h00, 32'h1600);
		xfer(1'b1, 8'h04, 32'h1);
		repeat (2) @(posedge clock);
		chk(32'(sap), 32'h0);
		chk(32'(wdn), 32'h1);
		tick_per(500);
		eoi_low(300);
		$display("long timing test done");
		xfer(1'b1, 8'h08, 32'hf);
		for (int i = 0; i < 33; i++) byte_in(8'(i));
		chk(32'(last_fwd), 32'ha5);
		rdc(8'h08, 32'ha, 32'ha);
		rdc(8'h10, 32'h4, 32'h4);
		xfer(1'b1, 8'h14, 32'h7);
		rdc(8'h18, 32'h7, 32'hff);
		xfer(1'b1, 8'h0c, 32'h0);
		rdc(8'h0c, 32'h0);
		chk(32'(irq), 32'h0);
		$display("buffer and mask test done");
		end_of_test();
	end
endmodule

bind fbs_mode_cfg fbs_mode_cfg_asserts #(.NUM_SAPS(NUM_SAPS), .EOI_LONG_CYC(EOI_LONG_CYC))
	i_fbs_mode_cfg_asserts (.clock(clock), .rstn(rstn), .psel(psel), .penable(penable),
	.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .pready(pready),
	.pslverr(pslverr), .irq(irq), .online(online), .slave_service_points(slave_service_points),
	.watchdog_normal(watchdog_normal), .prm_in(prm_in), .prm_fwd(prm_fwd));
